// >>> verilog/sdicg_consts.svh
// Constants of the checkfield generator: line numbers, sample codes.
// Assumes a 50 MHz sample clock and upstream line/word timing.
//
// Summary of operation
// R1: Pattern only inside active picture lines.
// R2: Upper part of each field repeats chroma 192, luma 102.
// R3: Lower part of each field repeats chroma 128, luma 68.
// R4: Last equalizer line chosen inside permitted window.
// R5: Switchover line identical every frame and field; the code reloads switch_sel at each frame start.
// R6: Every other frame, first luma becomes 100.
// R7: Chroma/luma ordering in pairs may be swapped.
// R8: Swapped ordering makes polarity word 128.
// R9: Equalizer pattern starts on first active line.
// R10: PLL pattern runs to last active line.
// R11: Switchover is a selectable window of lines.
// R12: Equalizer codes are 0x300 and 0x198.
// R13: Words run Cb, Y, Cr, Y; 3840 words.
`ifndef SDICG_CONSTS_SVH
`define SDICG_CONSTS_SVH
// ============================================================
// Sample codes
`define SDICG_EQ_C 10'h300
`define SDICG_EQ_Y 10'h198
`define SDICG_PLL_C 10'h200
`define SDICG_PLL_Y 10'h110
`define SDICG_POL_Y 10'h190
`define SDICG_POL_SWAP 10'h200
`define SDICG_BLANK 10'h000
// ============================================================
// Line timing
`define SDICG_WORDS 12'hF00
`define SDICG_LEG_F1 11'h029
`define SDICG_LEG_E1 11'h127
`define SDICG_LEG_L1 11'h22D
`define SDICG_LEG_F2 11'h25B
`define SDICG_LEG_E2 11'h35A
`define SDICG_LEG_L2 11'h460
`define SDICG_LEG_SPAN 3'h7
`define SDICG_625_F1 11'h02D
`define SDICG_625_E1 11'h149
`define SDICG_625_L1 11'h26C
`define SDICG_625_F2 11'h29E
`define SDICG_625_E2 11'h3BA
`define SDICG_625_L2 11'h4DD
`define SDICG_625_SPAN 3'h6
`define SDICG_CIFI_F1 11'h015
`define SDICG_CIFI_E1 11'h11F
`define SDICG_CIFI_L1 11'h230
`define SDICG_CIFI_F2 11'h248
`define SDICG_CIFI_E2 11'h352
`define SDICG_CIFI_L2 11'h463
`define SDICG_CIFI_SPAN 3'h6
`define SDICG_CIFP_F1 11'h02A
`define SDICG_CIFP_E1 11'h242
`define SDICG_CIFP_L1 11'h461
`define SDICG_CIFP_SPAN 3'h7
`endif

// >>> verilog/sdicg_pkg.sv
// Types shared by the checkfield generator modules.
// Assumes nothing beyond the constants header.
package sdicg_pkg;
   typedef enum logic [1:0] {
      SDICG_LEG = 2'h0,
      SDICG_625 = 2'h1,
      SDICG_CIFI = 2'h2,
      SDICG_CIFP = 2'h3
   } sdicg_sys_e;
   typedef enum logic [1:0] {
      RG_BLANK = 2'h0,
      RG_EQ = 2'h1,
      RG_PLL = 2'h3
   } sdicg_region_e;
   typedef logic [10:0] sdicg_line_t;
endpackage

// >>> verilog/sdicg_lines_if.sv
// Line classification carried between generator and line lookup.
// Assumes one clock domain; purely combinational signals.
`timescale 1ns/100ps
interface sdicg_lines_if;
   import sdicg_pkg::*;
   sdicg_sys_e sys;
   logic [2:0] sel;
   sdicg_line_t line;
   logic active;
   logic eq;
   logic first_line;
   modport gen (output sys, sel, line, input active, eq, first_line);
   modport lookup (input sys, sel, line, output active, eq, first_line);
endinterface

// >>> verilog/sdicg_lines.sv
// Line lookup: active picture bounds and switchover line per system.
// Assumes line numbers counted from 1 as on the link.
`timescale 1ns/100ps
`include "sdicg_consts.svh"
module sdicg_lines
   import sdicg_pkg::*;
(
   sdicg_lines_if.lookup lk
);
   sdicg_line_t f1, e1, l1, f2, e2, l2, sw1, sw2;
   logic [2:0] span, off;
   logic two;
   always_comb begin
      two = 1'b1;
      f2 = '0;
      e2 = '0;
      l2 = '0;
      case (lk.sys)
         SDICG_LEG: begin
            f1 = `SDICG_LEG_F1; e1 = `SDICG_LEG_E1; l1 = `SDICG_LEG_L1;
            f2 = `SDICG_LEG_F2; e2 = `SDICG_LEG_E2; l2 = `SDICG_LEG_L2;
            span = `SDICG_LEG_SPAN;
         end
         SDICG_625: begin
            f1 = `SDICG_625_F1; e1 = `SDICG_625_E1; l1 = `SDICG_625_L1;
            f2 = `SDICG_625_F2; e2 = `SDICG_625_E2; l2 = `SDICG_625_L2;
            span = `SDICG_625_SPAN;
         end
         SDICG_CIFI: begin
            f1 = `SDICG_CIFI_F1; e1 = `SDICG_CIFI_E1; l1 = `SDICG_CIFI_L1;
            f2 = `SDICG_CIFI_F2; e2 = `SDICG_CIFI_E2; l2 = `SDICG_CIFI_L2;
            span = `SDICG_CIFI_SPAN;
         end
         default: begin
            f1 = `SDICG_CIFP_F1; e1 = `SDICG_CIFP_E1; l1 = `SDICG_CIFP_L1;
            span = `SDICG_CIFP_SPAN;
            two = 1'b0;
         end
      endcase
      // Clamp the chosen offset into the permitted window
      off = (lk.sel > span) ? span : lk.sel; // R4 R11
      sw1 = e1 + sdicg_line_t'(off); // R5
      sw2 = e2 + sdicg_line_t'(off); // R5
   end
   logic in1, in2;
   assign in1 = (lk.line >= f1) && (lk.line <= l1); // R1 R9 R10
   assign in2 = two && (lk.line >= f2) && (lk.line <= l2); // R1 R9 R10
   assign lk.active = in1 || in2;
   assign lk.eq = (in1 && (lk.line <= sw1)) || (in2 && (lk.line <= sw2)); // R2 R3
   assign lk.first_line = (lk.line == f1); // R6
endmodule

// >>> verilog/sdicg_top.sv
// Checkfield generator: fills the active picture with the equalizer
// and PLL stress patterns and inserts the polarity control word.
// Assumes upstream timing gives line number and word index; the
// serializer and scrambler sit downstream.
`timescale 1ns/100ps
`include "sdicg_consts.svh"
module sdicg_top
   import sdicg_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] sys_sel,
   input wire logic swap_order,
   input wire logic [2:0] switch_sel,
   input wire logic [10:0] line_num,
   input wire logic [11:0] word_num,
   input wire logic word_valid,
   output logic [9:0] data_q,
   output logic valid_q,
   output logic eq_q,
   output logic pol_q,
   output logic frame_odd_q
);
   // ============================================================
   // Configuration, held for a whole frame
   sdicg_sys_e sys_q;
   logic swap_q;
   logic [2:0] sel_q;
   logic frame_start;
   sdicg_lines_if lk ();
   sdicg_lines u_lines (
      .lk(lk)
   );
   assign lk.sys = sys_q;
   assign lk.sel = sel_q;
   assign lk.line = line_num;
   assign frame_start = word_valid && lk.first_line && (word_num == 12'h000);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sys_q <= SDICG_LEG;
         swap_q <= 1'b0;
         sel_q <= 3'h0;
      end else if (frame_start) begin
         // Switchover only moves on a frame boundary
         sys_q <= sdicg_sys_e'(sys_sel); // R5
         swap_q <= swap_order; // R7
         sel_q <= switch_sel; // R5
      end
   end

   // ============================================================
   // Frame parity for the polarity control word
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         frame_odd_q <= 1'b0;
      end else if (frame_start) begin
         frame_odd_q <= ~frame_odd_q; // R6
      end
   end

   // ============================================================
   // Word selection
   sdicg_region_e region;
   logic in_word, is_luma, pol_hit;
   logic [9:0] c_val, y_val, data_d;
   assign in_word = word_valid && lk.active && (word_num < `SDICG_WORDS); // R1
   assign region = !in_word ? RG_BLANK : (lk.eq ? RG_EQ : RG_PLL);
   assign is_luma = word_num[0]; // R13
   assign pol_hit = in_word && lk.first_line && frame_odd_q &&
      (word_num == 12'h001); // R6

   always_comb begin
      c_val = `SDICG_BLANK;
      y_val = `SDICG_BLANK;
      data_d = `SDICG_BLANK;
      case (region)
         RG_EQ: begin
            c_val = `SDICG_EQ_C; // R2 R12
            y_val = `SDICG_EQ_Y; // R2 R12
         end
         RG_PLL: begin
            c_val = `SDICG_PLL_C; // R3
            y_val = `SDICG_PLL_Y; // R3
         end
         default: begin
            c_val = `SDICG_BLANK;
            y_val = `SDICG_BLANK;
         end
      endcase
      if (region != RG_BLANK) begin
         // Swapped order puts the luma value in chroma slots
         data_d = (is_luma ^ swap_q) ? y_val : c_val; // R7 R13
      end
      if (pol_hit) begin
         data_d = swap_q ? `SDICG_POL_SWAP : `SDICG_POL_Y; // R6 R8
      end
   end

   // ============================================================
   // Output registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         data_q <= `SDICG_BLANK;
         valid_q <= 1'b0;
         eq_q <= 1'b0;
         pol_q <= 1'b0;
      end else begin
         data_q <= data_d;
         valid_q <= in_word; // R1
         eq_q <= (region == RG_EQ); // R2
         pol_q <= pol_hit; // R6
      end
   end

   // ============================================================
   // Checks
   property p_confine;
      @(posedge clk) disable iff (!rst_n)
      !lk.active |=> !valid_q && (data_q == `SDICG_BLANK);
   endproperty
   a_confine: assert property (p_confine) // R1
      else $error("pattern outside active picture");

   property p_eq_words;
      @(posedge clk) disable iff (!rst_n)
      in_word && lk.eq && !swap_q && !pol_hit |=>
         data_q == ($past(word_num[0]) ? 10'h198 : 10'h300);
   endproperty
   a_eq_words: assert property (p_eq_words) // R2
      else $error("equalizer word wrong");

   property p_pll_words;
      @(posedge clk) disable iff (!rst_n)
      in_word && !lk.eq && !swap_q |=>
         data_q == ($past(word_num[0]) ? 10'h110 : 10'h200);
   endproperty
   a_pll_words: assert property (p_pll_words) // R3
      else $error("PLL word wrong");

   property p_window;
      @(posedge clk) disable iff (!rst_n)
      sys_q == SDICG_LEG |->
         ((line_num == 11'h127) -> lk.eq) && ((line_num == 11'h12F) -> !lk.eq) &&
         ((line_num == 11'h35A) -> lk.eq) && ((line_num == 11'h362) -> !lk.eq);
   endproperty
   a_window: assert property (p_window) // R4
      else $error("switchover outside window");

   property p_stable_cfg;
      @(posedge clk) disable iff (!rst_n)
      !frame_start |=> $stable(sel_q) && $stable(sys_q);
   endproperty
   a_stable_cfg: assert property (p_stable_cfg) // R5
      else $error("switchover moved mid frame");

   property p_pol;
      @(posedge clk) disable iff (!rst_n)
      in_word && lk.first_line && word_num == 12'h001 && !swap_q |=>
         data_q == (frame_odd_q ? 10'h190 : 10'h198);
   endproperty
   a_pol: assert property (p_pol) // R6
      else $error("polarity word wrong");

   property p_swap;
      @(posedge clk) disable iff (!rst_n)
      in_word && lk.eq && swap_q && !word_num[0] |=> data_q == 10'h198;
   endproperty
   a_swap: assert property (p_swap) // R7
      else $error("swapped order wrong");

   property p_pol_swap;
      @(posedge clk) disable iff (!rst_n)
      pol_hit && swap_q |=> data_q == 10'h200 && pol_q;
   endproperty
   a_pol_swap: assert property (p_pol_swap) // R8
      else $error("swapped polarity word wrong");

   property p_first;
      @(posedge clk) disable iff (!rst_n)
      sys_q == SDICG_LEG |->
         ((line_num == 11'h029) -> (lk.active && lk.eq)) &&
         ((line_num == 11'h028) -> !lk.active) &&
         ((line_num == 11'h25B) -> lk.eq);
   endproperty
   a_first: assert property (p_first) // R9
      else $error("equalizer start line wrong");

   property p_last;
      @(posedge clk) disable iff (!rst_n)
      sys_q == SDICG_LEG |->
         ((line_num == 11'h22D) -> (lk.active && !lk.eq)) &&
         ((line_num == 11'h460) -> (lk.active && !lk.eq)) &&
         ((line_num == 11'h461) -> !lk.active);
   endproperty
   a_last: assert property (p_last) // R10
      else $error("PLL end line wrong");

   property p_last_prog;
      @(posedge clk) disable iff (!rst_n)
      sys_q == SDICG_CIFP |->
         ((line_num == 11'h461) -> (lk.active && !lk.eq)) &&
         ((line_num == 11'h462) -> !lk.active);
   endproperty
   a_last_prog: assert property (p_last_prog) // R10
      else $error("progressive end line wrong");

   property p_sel_effect;
      @(posedge clk) disable iff (!rst_n)
      sys_q == SDICG_625 && line_num == 11'h149 + 11'(sel_q) && sel_q <= 3'h6 |->
         lk.eq;
   endproperty
   a_sel_effect: assert property (p_sel_effect) // R11
      else $error("chosen switchover line ignored");

   property p_luma_code;
      @(posedge clk) disable iff (!rst_n)
      in_word && lk.eq && word_num[0] && !swap_q && !pol_hit |=>
         data_q == 10'h198 && valid_q && eq_q;
   endproperty
   a_luma_code: assert property (p_luma_code) // R12
      else $error("equalizer luma code wrong");

   property p_word_count;
      @(posedge clk) disable iff (!rst_n)
      word_valid && word_num >= 12'hF00 |=> !valid_q;
   endproperty
   a_word_count: assert property (p_word_count) // R13
      else $error("word beyond active line");
endmodule

// >>> tb/sdicg_serializer_model.sv
// Serializer model: takes the checkfield stream and counts its words.
// Assumes the generator's registered outputs on the same clock.
`timescale 1ns/100ps
module sdicg_serializer_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [9:0] data,
   input wire logic valid,
   output logic [31:0] n_words,
   output logic [31:0] n_bad
);
   // ============================================================
   // Word intake; reserved codes must never carry picture data
   always @(posedge clk) begin
      if (!rst_n) begin
         n_words <= 32'h0;
         n_bad <= 32'h0;
      end else if (valid) begin
         n_words <= n_words + 32'h1;
         if (data < 10'h004 || data > 10'h3FB)
            n_bad <= n_bad + 32'h1;
      end
   end
endmodule

// >>> tb/tb_sdicg_top.sv
// Testbench for the checkfield generator, with a serializer model.
// Assumes the design files and the serializer model compile first.
`timescale 1ns/100ps
module tb_sdicg_top
   import sdicg_pkg::*;
;
   typedef struct {logic [13:0] e; int due;} sdicg_note_s;
   logic clk = 0;
   logic rst_n = 0;
   logic [1:0] sys_sel = 0;
   logic swap_order = 0;
   logic [2:0] switch_sel = 0;
   logic [10:0] line_num = 0;
   logic [11:0] word_num = 0;
   logic word_valid = 0;
   logic [9:0] data_q;
   logic valid_q, eq_q, pol_q, frame_odd_q;
   logic [31:0] n_ser, n_bad;
   int errors = 0, n_compared = 0, cyc = 0, n_valid = 0;
   int m_sys = 0, m_swap = 0, m_sel = 0, m_odd = 0, n_sys = 0, n_swap = 0, n_sel = 0;
   int f1[4] = '{41, 45, 21, 42};
   int e1[4] = '{295, 329, 287, 578};
   int l1[4] = '{557, 620, 560, 1121};
   int f2[4] = '{603, 670, 584, 0};
   int e2[4] = '{858, 954, 850, 0};
   int l2[4] = '{1120, 1245, 1123, 0};
   int span[4] = '{7, 6, 6, 7};
   sdicg_note_s q[$];

   always #10 clk = ~clk;

   sdicg_top dut (.clk, .rst_n, .sys_sel, .swap_order, .switch_sel, .line_num, .word_num,
      .word_valid, .data_q, .valid_q, .eq_q, .pol_q, .frame_odd_q);
   sdicg_serializer_model ser (.clk, .rst_n, .data(data_q), .valid(valid_q), .n_words(n_ser),
      .n_bad(n_bad));

   // ============================================================
   // Reporting
   task automatic stop_test;
      $display("errors %0d, compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic cmp_word(input logic [13:0] got, input logic [13:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: word got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cmp_count(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: count got %0d exp %0d", $time, got, exp);
      end
   endtask

   // ============================================================
   // Expected word from the shadow configuration
   function automatic logic [12:0] expect_word(input int ln, input int wd, input bit vld);
      int k;
      bit act, eq, pol;
      logic [9:0] d;
      k = m_sel > span[m_sys] ? span[m_sys] : m_sel;
      act = vld && wd < 3840 && ((ln >= f1[m_sys] && ln <= l1[m_sys]) ||
         (f2[m_sys] != 0 && ln >= f2[m_sys] && ln <= l2[m_sys]));
      eq = act && (ln <= e1[m_sys] + k || (f2[m_sys] != 0 && ln >= f2[m_sys] &&
         ln <= e2[m_sys] + k));
      pol = act && m_odd != 0 && ln == f1[m_sys] && wd == 1;
      if (!act)
         d = 10'h000;
      else if (pol)
         d = m_swap != 0 ? 10'h200 : 10'h190;
      else if ((wd % 2 == 1) ^ (m_swap != 0))
         d = eq ? 10'h198 : 10'h110;
      else
         d = eq ? 10'h300 : 10'h200;
      return {d, act, eq, pol};
   endfunction

   // ============================================================
   // Driver and monitor
   task automatic drv(input int ln, input int wd, input bit vld);
      logic [12:0] e;
      @(posedge clk);
      line_num <= ln[10:0];
      word_num <= wd[11:0];
      word_valid <= vld;
      sys_sel <= n_sys[1:0];
      swap_order <= n_swap[0];
      switch_sel <= n_sel[2:0];
      e = expect_word(ln, wd, vld);
      if (vld && wd == 0 && ln == f1[m_sys]) begin
         m_sys = n_sys;
         m_swap = n_swap;
         m_sel = n_sel;
         m_odd = !m_odd;
      end
      n_valid += e[2];
      q.push_back('{{e, m_odd[0]}, cyc + 2});
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc > 3000) begin
         errors++;
         stop_test();
      end
   end

   always @(negedge clk) begin
      if (q.size() != 0 && q[0].due == cyc) begin
         cmp_word({data_q, valid_q, eq_q, pol_q, frame_odd_q}, q[0].e);
         q.delete(0);
      end
   end

   // ============================================================
   // Frames over all systems, both parities, changing config mid-frame
   initial begin
      int k;
      int ls[11];
      void'($urandom(69158));
      repeat (8) @(posedge clk);
      rst_n <= 1;
      for (int fr = 0; fr < 8; fr++) begin
         drv(f1[m_sys], 0, 1);
         for (int w = 1; w < 4; w++)
            drv(f1[m_sys], w, 1);
         drv(f1[m_sys], 3839, 1);
         drv(f1[m_sys], 3840, 1);
         n_sys = (fr + 1) / 2;
         // Frame two has the polarity word, so force swapped order there once
         n_swap = fr == 1 ? 1 : $urandom_range(1);
         n_sel = fr % 2 == 1 ? 7 : $urandom_range(6);
         k = m_sel > span[m_sys] ? span[m_sys] : m_sel;
         ls = '{f1[m_sys] - 1, e1[m_sys] + k, e1[m_sys] + k + 1, l1[m_sys], l1[m_sys] + 1,
            f2[m_sys] - 1, f2[m_sys], e2[m_sys] + k, e2[m_sys] + k + 1, l2[m_sys], l2[m_sys] + 1};
         foreach (ls[i]) begin
            drv(ls[i], $urandom_range(3839), 1);
            drv(ls[i], $urandom_range(3839), 0);
         end
      end
      repeat (3) @(posedge clk);
      cmp_count(n_ser, n_valid);
      cmp_count(n_bad, 0);
      cmp_count(q.size(), 0);
      stop_test();
   end
endmodule
